// ===== hdl/smbus_slave_pkg.sv
/*
 * Shared constants for the slave write decoder: register numbers,
 * command codes, reset control values and frame layout.
 * Assumes a single 200 MHz clock domain.
 */
`default_nettype none

package smbus_slave_pkg;

    // ------------------------------------------------------------
    // Slave register numbers
    // ------------------------------------------------------------
    localparam logic [7:0] REG_COMMAND  = 8'h00;
    localparam logic [7:0] REG_MSG_LOW  = 8'h04;
    localparam logic [7:0] REG_MSG_HIGH = 8'h05;

    // ------------------------------------------------------------
    // Address and frame layout
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h44;
    localparam logic       WRITE_BIT          = 1'b0;
    localparam logic [2:0] LAST_BIT           = 3'h7;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_WAKE_SMI    = 8'h01;
    localparam logic [7:0] CMD_POWERDOWN   = 8'h02;
    localparam logic [7:0] CMD_RESET_WARM  = 8'h03;
    localparam logic [7:0] CMD_RESET_COLD  = 8'h04;
    localparam logic [7:0] CMD_MSG_DISABLE = 8'h05;
    localparam logic [7:0] CMD_WATCHDOG_RELOAD_COMMAND   = 8'h06;

    // ------------------------------------------------------------
    // Reset control bits 3:1
    // ------------------------------------------------------------
    localparam logic [2:0] RESET_BITS_WARM  = 3'h3;
    localparam logic [2:0] RESET_BITS_COLD  = 3'h7;
    localparam logic [2:0] RESET_BITS_RESET = 3'h0;

    typedef enum logic [1:0] {mgmt_on, mgmt_gated, mgmt_off} mgmt_power_t;

endpackage

`default_nettype wire

// ===== hdl/slave_cmd_if.sv
/*
 * Carries one decoded command byte from the bus front end to the
 * command executor. Assumes both ends share mclk.
 */
`default_nettype none

interface slave_cmd_if;
    logic       cmd_valid;
    logic [7:0] cmd_code;
    modport source (output cmd_valid, output cmd_code);
    modport sink   (input cmd_valid, input cmd_code);
endinterface

`default_nettype wire

// ===== hdl/slave_command_executor.sv
/*
 * Executes command bytes written to slave register 0.
 * Assumes power state inputs are synchronous to mclk.
 */
`default_nettype none

module slave_command_executor (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    slave_cmd_if.sink                         cmd_bus,
    input  wire logic                         resume_well_reset_n,
    input  wire logic                         system_in_s0,
    input  wire smbus_slave_pkg::mgmt_power_t mgmt_power,
    input  wire logic                         graceful_sleep_entry,
    input  wire logic                         smbus_wake_status_clear,
    input  wire logic                         power_button_override_status_clear,
    output logic                              smbus_wake_status,
    output logic                              power_button_override_status,
    output logic                              wake_request,
    output logic                              system_management_interrupt_n,
    output logic                              powerdown_request,
    output logic                              reset_control_write,
    output logic [2:0]                        reset_control_bits,
    output logic                              message_send_enable,
    output logic                              watchdog_reload_command
);

    function automatic logic hit(input logic v, input logic [7:0] c, input logic [7:0] want);
        return v && (c == want);
    endfunction

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire do_wake  = hit(cmd_bus.cmd_valid, cmd_bus.cmd_code, smbus_slave_pkg::CMD_WAKE_SMI);
    wire do_pdown = hit(cmd_bus.cmd_valid, cmd_bus.cmd_code, smbus_slave_pkg::CMD_POWERDOWN);
    wire do_warm  = hit(cmd_bus.cmd_valid, cmd_bus.cmd_code, smbus_slave_pkg::CMD_RESET_WARM);
    wire do_cold  = hit(cmd_bus.cmd_valid, cmd_bus.cmd_code, smbus_slave_pkg::CMD_RESET_COLD);
    wire do_msg   = hit(cmd_bus.cmd_valid, cmd_bus.cmd_code, smbus_slave_pkg::CMD_MSG_DISABLE);
    wire do_wd    = hit(cmd_bus.cmd_valid, cmd_bus.cmd_code, smbus_slave_pkg::CMD_WATCHDOG_RELOAD_COMMAND); // RULE19
    wire warm_ok  = do_warm & system_in_s0; // RULE12
    wire cold_ok  = do_cold & (system_in_s0 | (mgmt_power != smbus_slave_pkg::mgmt_off)
                    | graceful_sleep_entry); // RULE15

    // ------------------------------------------------------------
    // Actions
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wake_request                  <= 1'b0;
            system_management_interrupt_n <= 1'b1;
            powerdown_request             <= 1'b0;
            reset_control_write           <= 1'b0;
            reset_control_bits            <= smbus_slave_pkg::RESET_BITS_RESET;
            watchdog_reload_command       <= 1'b0;
        end
        else
        begin
            wake_request                  <= do_wake & ~system_in_s0; // RULE7
            system_management_interrupt_n <= ~(do_wake & system_in_s0); // RULE7
            powerdown_request             <= do_pdown; // RULE9
            reset_control_write           <= warm_ok | cold_ok; // RULE10
            if (warm_ok)
                reset_control_bits <= smbus_slave_pkg::RESET_BITS_WARM; // RULE11
            else if (cold_ok)
                reset_control_bits <= smbus_slave_pkg::RESET_BITS_COLD; // RULE13 RULE14
            watchdog_reload_command       <= do_wd; // RULE18
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            smbus_wake_status            <= 1'b0;
            power_button_override_status <= 1'b0;
        end
        else
        begin
            if (do_wake)
                smbus_wake_status <= 1'b1; // RULE8
            else if (smbus_wake_status_clear)
                smbus_wake_status <= 1'b0;
            if (do_pdown)
                power_button_override_status <= 1'b1; // RULE9
            else if (power_button_override_status_clear)
                power_button_override_status <= 1'b0;
        end
    end

    // Only the resume-well reset re-enables messages
    always_ff @(posedge mclk)
    begin
        if (!resume_well_reset_n)
            message_send_enable <= 1'b1; // RULE17
        else if (do_msg)
            message_send_enable <= 1'b0; // RULE16
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_wake_awake;
        @(posedge mclk) disable iff (rst)
        do_wake && system_in_s0 |=> !system_management_interrupt_n && !wake_request && smbus_wake_status;
    endproperty
    a_wake_awake: assert property (p_wake_awake) else $error("wake command while awake gave no SMI"); // RULE7

    property p_wake_asleep;
        @(posedge mclk) disable iff (rst)
        do_wake && !system_in_s0 |=> wake_request && system_management_interrupt_n && smbus_wake_status;
    endproperty
    a_wake_asleep: assert property (p_wake_asleep) else $error("wake command while asleep gave no wake"); // RULE8

    property p_warm_dropped;
        @(posedge mclk) disable iff (rst)
        do_warm && !system_in_s0 |=> !reset_control_write;
    endproperty
    a_warm_dropped: assert property (p_warm_dropped) else $error("warm reset taken outside S0"); // RULE12

    property p_warm_value;
        @(posedge mclk) disable iff (rst)
        warm_ok |=> reset_control_write && reset_control_bits == smbus_slave_pkg::RESET_BITS_WARM;
    endproperty
    a_warm_value: assert property (p_warm_value) else $error("warm reset bits wrong"); // RULE11

    property p_cold_gate;
        @(posedge mclk) disable iff (rst)
        do_cold && !system_in_s0 && mgmt_power == smbus_slave_pkg::mgmt_off && !graceful_sleep_entry
        |=> !reset_control_write;
    endproperty
    a_cold_gate: assert property (p_cold_gate) else $error("cold reset taken without graceful entry"); // RULE15

    property p_msg_off;
        @(posedge mclk) disable iff (rst)
        do_msg && resume_well_reset_n ##1 resume_well_reset_n [*2] |-> !message_send_enable;
    endproperty
    a_msg_off: assert property (p_msg_off) else $error("messages re-enabled without resume reset"); // RULE16

endmodule

`default_nettype wire

// ===== hdl/smbus_slave_write_decoder.sv
/*
 * SMBus slave byte-write front end with its register file:
 * address match, acknowledge, command and message byte registers.
 * Assumes smb_clk_in and smb_data_in are already synchronous to
 * mclk and sampled well above the bus bit rate.
 */
`default_nettype none

// Function
// RULE1: Byte write is command byte then data
// RULE2: Decode at programmable address, default preset
// RULE3: Register 0 takes command codes
// RULE4: Registers 4 and 5 hold message bytes
// RULE5: Master waits for processor read first
// RULE6: Write and read race is unprotected
// RULE7: Code 1 wakes asleep, SMI when awake
// RULE8: Code 1 always sets wake status
// RULE9: Code 2 sets override status, powers down
// RULE10: Code 3 hard reset without power cycle
// RULE11: Code 3 equals reset bits 2:1 set
// RULE12: Code 3 dropped outside S0
// RULE13: Code 4 hard reset with power cycle
// RULE14: Code 4 equals reset bits 3:1 set
// RULE15: Code 4 gated by management power state
// RULE16: Code 5 stops heartbeat and event messages
// RULE17: Only resume reset re-enables messages
// RULE18: Code 6 reloads the watchdog
// RULE19: Codes 0, 7, undefined do nothing
// RULE20: Reserved registers accept writes, no effect
module smbus_slave_write_decoder (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    input  wire logic                         resume_well_reset_n,
    input  wire logic                         smb_clk_in,
    input  wire logic                         smb_data_in,
    output logic                              smb_data_out,
    output logic                              smb_data_oe_n,
    input  wire logic                         slave_address_write,
    input  wire logic [6:0]                   slave_address_value,
    output logic [6:0]                        receive_slave_address,
    output logic [7:0]                        message_byte_low,
    output logic [7:0]                        message_byte_high,
    input  wire logic                         system_in_s0,
    input  wire smbus_slave_pkg::mgmt_power_t mgmt_power,
    input  wire logic                         graceful_sleep_entry,
    input  wire logic                         smbus_wake_status_clear,
    input  wire logic                         power_button_override_status_clear,
    output logic                              smbus_wake_status,
    output logic                              power_button_override_status,
    output logic                              wake_request,
    output logic                              system_management_interrupt_n,
    output logic                              powerdown_request,
    output logic                              reset_control_write,
    output logic [2:0]                        reset_control_bits,
    output logic                              message_send_enable,
    output logic                              watchdog_reload_command
);

    typedef enum logic [2:0] {st_idle, st_addr, st_cmd, st_data, st_done} frame_state_t;

    frame_state_t state;
    logic         scl_q;
    logic         sda_q;
    logic [2:0]   bit_count;
    logic [7:0]   shift;
    logic         ack_due;
    logic         ack_drive;
    logic [7:0]   reg_index;
    logic         write_strobe;
    logic [7:0]   write_data;

    slave_cmd_if cmd_bus ();

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= smb_clk_in;
            sda_q <= smb_data_in;
        end
    end

    wire       scl_rise   = smb_clk_in & ~scl_q;
    wire       scl_fall   = ~smb_clk_in & scl_q;
    wire       start_cond = smb_clk_in & scl_q & sda_q & ~smb_data_in;
    wire       stop_cond  = smb_clk_in & scl_q & ~sda_q & smb_data_in;
    wire       in_byte    = (state == st_addr) || (state == st_cmd) || (state == st_data);
    wire       bit_take   = scl_rise & ~ack_drive & in_byte;
    wire       byte_end   = bit_take & (bit_count == smbus_slave_pkg::LAST_BIT);
    wire [7:0] next_shift = {shift[6:0], smb_data_in};
    wire       addr_hit   = (next_shift[7:1] == receive_slave_address)
                            && (next_shift[0] == smbus_slave_pkg::WRITE_BIT); // RULE2

    // ------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst || stop_cond)
            state <= st_idle;
        else if (start_cond)
            state <= st_addr;
        else if (byte_end && state == st_addr && !addr_hit)
            state <= st_done; // RULE2
        else if (scl_fall && ack_drive)
        begin
            case (state)
                st_addr: state <= st_cmd; // RULE1
                st_cmd:  state <= st_data;
                default: state <= st_done;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst || start_cond)
            bit_count <= 3'h0;
        else if (bit_take)
            bit_count <= bit_count + 3'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            shift <= 8'h00;
        else if (bit_take)
            shift <= next_shift;
    end

    // ------------------------------------------------------------
    // Acknowledge drive, low from the falling edge after a byte
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst || start_cond || stop_cond)
            ack_due <= 1'b0;
        else if (byte_end && (state != st_addr || addr_hit))
            ack_due <= 1'b1;
        else if (scl_fall)
            ack_due <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (rst || start_cond || stop_cond)
            ack_drive <= 1'b0;
        else if (scl_fall)
            ack_drive <= ack_due;
    end

    assign smb_data_out  = 1'b0;
    assign smb_data_oe_n = ~ack_drive;

    // ------------------------------------------------------------
    // Register write capture
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
            reg_index <= smbus_slave_pkg::REG_COMMAND;
        else if (byte_end && state == st_cmd)
            reg_index <= next_shift; // RULE1
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            write_strobe <= 1'b0;
            write_data   <= 8'h00;
        end
        else
        begin
            write_strobe <= byte_end && state == st_data;
            if (byte_end && state == st_data)
                write_data <= next_shift;
        end
    end

    wire wr_command = write_strobe && reg_index == smbus_slave_pkg::REG_COMMAND; // RULE3
    wire wr_low     = write_strobe && reg_index == smbus_slave_pkg::REG_MSG_LOW;
    wire wr_high    = write_strobe && reg_index == smbus_slave_pkg::REG_MSG_HIGH; // RULE20

    // Newest byte always overwrites; a processor read in the same cycle
    // may see either value
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            message_byte_low  <= 8'h00;
            message_byte_high <= 8'h00;
        end
        else
        begin
            if (wr_low)
                message_byte_low <= write_data; // RULE4 RULE6
            if (wr_high)
                message_byte_high <= write_data; // RULE4
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            receive_slave_address <= smbus_slave_pkg::SLAVE_ADDR_DEFAULT; // RULE2
        else if (slave_address_write)
            receive_slave_address <= slave_address_value;
    end

    assign cmd_bus.cmd_valid = wr_command; // RULE3
    assign cmd_bus.cmd_code  = write_data;

    // ------------------------------------------------------------
    // Command execution
    // ------------------------------------------------------------
    slave_command_executor u_exec (
        .mclk                               (mclk),
        .rst                                (rst),
        .cmd_bus                            (cmd_bus),
        .resume_well_reset_n                (resume_well_reset_n),
        .system_in_s0                       (system_in_s0),
        .mgmt_power                         (mgmt_power),
        .graceful_sleep_entry               (graceful_sleep_entry),
        .smbus_wake_status_clear            (smbus_wake_status_clear),
        .power_button_override_status_clear (power_button_override_status_clear),
        .smbus_wake_status                  (smbus_wake_status),
        .power_button_override_status       (power_button_override_status),
        .wake_request                       (wake_request),
        .system_management_interrupt_n      (system_management_interrupt_n),
        .powerdown_request                  (powerdown_request),
        .reset_control_write                (reset_control_write),
        .reset_control_bits                 (reset_control_bits),
        .message_send_enable                (message_send_enable),
        .watchdog_reload_command            (watchdog_reload_command)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_addr_miss;
        @(posedge mclk) disable iff (rst)
        byte_end && state == st_addr && !addr_hit |=> state == st_done && !ack_due;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address was accepted"); // RULE2

    property p_addr_ack;
        @(posedge mclk) disable iff (rst)
        ack_due && scl_fall && !start_cond && !stop_cond |=> !smb_data_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("acknowledge not driven"); // RULE1

    property p_index;
        @(posedge mclk) disable iff (rst)
        byte_end && state == st_cmd |=> reg_index == $past(next_shift);
    endproperty
    a_index: assert property (p_index) else $error("command byte not held as index"); // RULE1

    property p_command;
        @(posedge mclk) disable iff (rst)
        byte_end && state == st_data && reg_index == smbus_slave_pkg::REG_COMMAND
        |=> cmd_bus.cmd_valid && cmd_bus.cmd_code == $past(next_shift);
    endproperty
    a_command: assert property (p_command) else $error("command byte not issued"); // RULE3

    property p_msg_low;
        @(posedge mclk) disable iff (rst)
        wr_low |=> message_byte_low == $past(write_data) && $stable(message_byte_high);
    endproperty
    a_msg_low: assert property (p_msg_low) else $error("low message byte not stored"); // RULE4

    property p_msg_high;
        @(posedge mclk) disable iff (rst)
        wr_high |=> message_byte_high == $past(write_data) && $stable(message_byte_low);
    endproperty
    a_msg_high: assert property (p_msg_high) else $error("high message byte not stored"); // RULE4

    property p_reserved;
        @(posedge mclk) disable iff (rst)
        write_strobe && !wr_command && !wr_low && !wr_high
        |-> !cmd_bus.cmd_valid ##1 $stable(message_byte_low) && $stable(message_byte_high);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved register changed state"); // RULE20

    property p_idle_codes;
        @(posedge mclk) disable iff (rst)
        cmd_bus.cmd_valid && (cmd_bus.cmd_code == 8'h00 || cmd_bus.cmd_code > 8'h06)
        |=> !wake_request && system_management_interrupt_n && !powerdown_request
            && !reset_control_write && !watchdog_reload_command;
    endproperty
    a_idle_codes: assert property (p_idle_codes) else $error("undefined code caused an action"); // RULE19

    property p_reload;
        @(posedge mclk) disable iff (rst)
        cmd_bus.cmd_valid && cmd_bus.cmd_code == smbus_slave_pkg::CMD_WATCHDOG_RELOAD_COMMAND
        |=> watchdog_reload_command ##1 !watchdog_reload_command;
    endproperty
    a_reload: assert property (p_reload) else $error("watchdog reload not pulsed"); // RULE18

    property p_pdown;
        @(posedge mclk) disable iff (rst)
        cmd_bus.cmd_valid && cmd_bus.cmd_code == smbus_slave_pkg::CMD_POWERDOWN
        |=> powerdown_request && power_button_override_status;
    endproperty
    a_pdown: assert property (p_pdown) else $error("powerdown command not honoured"); // RULE9

    property p_single_write;
        @(posedge mclk) disable iff (rst)
        write_strobe |=> !write_strobe [*8];
    endproperty
    a_single_write: assert property (p_single_write) else $error("data byte strobed twice"); // RULE1

endmodule

`default_nettype wire

// ===== sim/smbus_master_model.sv
/* Master model that sends byte-write frames and samples the acks.
   Assumes one mclk and the slave's active low data enable oe_n. */
`default_nettype none
module smbus_master_model (
    input  wire logic mclk,
    input  wire logic oe_n,
    output logic      scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    initial scl = 1'b1;
    // Released wire reads high through the pull-up
    assign sda = drv & oe_n;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Start, three bytes MSB first each with an ack slot, stop
    task automatic frame(input logic [23:0] f, output logic ack);
        ack = 1'b1;
        drv <= 1'b0;
        tick(4);
        for (int i = 23; i >= 0; i--)
        begin
            scl <= 1'b0;
            drv <= f[i];
            tick(4);
            scl <= 1'b1;
            tick(4);
            if (i % 8 == 0)
            begin
                scl <= 1'b0;
                drv <= 1'b1;
                tick(4);
                scl <= 1'b1;
                tick(2);
                ack &= !sda;
                tick(2);
            end
        end
        scl <= 1'b0;
        drv <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        drv <= 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
/* Bench for the slave write decoder: frames from the master model,
   then checks of message bytes, pulses and status levels.
   Assumes the package and master model are compiled first. */
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; $display("ERROR %0t: line %0d", $time, `__LINE__); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1, rwr_n = 1'b0, awr = 1'b0, s0 = 1'b1, grace = 1'b0, wclr = 1'b0, oclr = 1'b0;
    logic [6:0] aval = 7'h44;
    smbus_slave_pkg::mgmt_power_t mgmt = smbus_slave_pkg::mgmt_off;
    wire scl, sda, oe_n, sdo, wsts, osts, wake, smi_n, pd, rcw, mse, wdr;
    wire [6:0] rsa;
    wire [7:0] mlo, mhi;
    wire [2:0] rbits;
    wire [4:0] pulses = {wake, !smi_n, pd, rcw, wdr};
    int num_errors = 0, checks = 0, cnt[5] = '{0, 0, 0, 0, 0};
    logic ack;
    always #2.5 mclk = !mclk;
    always @(posedge mclk)
        for (int i = 0; i < 5; i++) cnt[i] += int'(pulses[i] === 1'b1);
    smbus_master_model m (.mclk(mclk), .oe_n(oe_n), .scl(scl), .sda(sda));
    smbus_slave_write_decoder dut (.mclk(mclk), .rst(rst), .resume_well_reset_n(rwr_n), .smb_clk_in(scl),
        .smb_data_in(sda), .smb_data_out(sdo), .smb_data_oe_n(oe_n), .slave_address_write(awr),
        .slave_address_value(aval), .receive_slave_address(rsa), .message_byte_low(mlo),
        .message_byte_high(mhi), .system_in_s0(s0), .mgmt_power(mgmt), .graceful_sleep_entry(grace),
        .smbus_wake_status_clear(wclr), .power_button_override_status_clear(oclr),
        .smbus_wake_status(wsts), .power_button_override_status(osts), .wake_request(wake),
        .system_management_interrupt_n(smi_n), .powerdown_request(pd), .reset_control_write(rcw),
        .reset_control_bits(rbits), .message_send_enable(mse), .watchdog_reload_command(wdr));
    task automatic tally_and_finish;
        $display("Errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Pulses seen: wake, smi, powerdown, reset write, watchdog reload
    task automatic go(input logic [7:0] r, input logic [7:0] d, input logic [4:0] e);
        int b[5];
        logic [4:0] g;
        b = cnt;
        m.frame({8'h88, r, d}, ack);
        for (int i = 0; i < 5; i++) g[i] = 1'(cnt[i] - b[i]);
        `CHK({ack, g}, {1'b1, e})
    endtask
    initial
    begin
        #100us;
        num_errors++;
        tally_and_finish;
    end
    initial
    begin
        m.tick(2);
        rst <= 1'b0;
        rwr_n <= 1'b1;
        m.tick(1);
        `CHK({rsa, mlo, mhi, wsts, osts, mse, oe_n, sdo}, {7'h44, 16'h0000, 3'h1, 2'h2})
        go(8'h04, 8'ha5, 5'h00);
        go(8'h05, 8'h3c, 5'h00);
        `CHK({mlo, mhi}, 16'ha53c)
        go(8'h04, 8'h5a, 5'h00);
        go(8'h02, 8'hff, 5'h00);
        go(8'h06, 8'h01, 5'h00);
        `CHK({mlo, mhi}, 16'h5a3c)
        for (int i = 0; i < 5; i++) go(8'h00, (i < 2) ? 8'(7 * i) : 8'(7 + i), 5'h00);
        go(8'h00, 8'h01, 5'h08);
        `CHK(wsts, 1'b1)
        wclr <= 1'b1;
        s0 <= 1'b0;
        m.tick(1);
        wclr <= 1'b0;
        m.tick(1);
        `CHK(wsts, 1'b0)
        go(8'h00, 8'h01, 5'h10);
        `CHK(wsts, 1'b1)
        go(8'h00, 8'h02, 5'h04);
        `CHK(osts, 1'b1)
        oclr <= 1'b1;
        m.tick(1);
        oclr <= 1'b0;
        m.tick(1);
        `CHK(osts, 1'b0)
        go(8'h00, 8'h03, 5'h00);
        go(8'h00, 8'h04, 5'h00);
        mgmt <= smbus_slave_pkg::mgmt_gated;
        go(8'h00, 8'h04, 5'h02);
        `CHK(rbits, 3'h7)
        mgmt <= smbus_slave_pkg::mgmt_off;
        grace <= 1'b1;
        s0 <= 1'b1;
        go(8'h00, 8'h03, 5'h02);
        `CHK(rbits, 3'h3)
        s0 <= 1'b0;
        go(8'h00, 8'h04, 5'h02);
        `CHK(rbits, 3'h7)
        go(8'h00, 8'h06, 5'h01);
        go(8'h00, 8'h05, 5'h00);
        `CHK(mse, 1'b0)
        rst <= 1'b1;
        m.tick(2);
        rst <= 1'b0;
        m.tick(2);
        `CHK(mse, 1'b0)
        m.frame(24'h8a_0477, ack);
        `CHK({ack, mlo}, 9'h000)
        rwr_n <= 1'b0;
        aval <= 7'h45;
        awr <= 1'b1;
        m.tick(1);
        rwr_n <= 1'b1;
        awr <= 1'b0;
        m.frame(24'h8a_0477, ack);
        `CHK({ack, mlo, mse}, 10'h2ef)
        tally_and_finish;
    end
endmodule
`default_nettype wire
